// *** hdl/sbd_base_decoder.sv ***
// Super-wideband base extension layer decoder, top level.
`timescale 1ns/1ps
`include "sbd_cfg.svh"
// ============================================================
module sbd_base_decoder (
    input logic clk_sys,
    input logic rst_n,
    input logic frame_start,
    input logic frame_erased,
    input logic [1:0] class_code,
    input logic [4:0] gain_idx,
    input logic [31:0] spec_idx,
    input logic [1:0] codebook_select_flag,
    input logic [15:0] tenv_idx,
    input logic tenv_adj_bit,
    input logic shb_mode_flag,
    input logic first_enhancement_layer_ok,
    input logic second_enhancement_layer_ok,
    input logic [7:0] unused_bits_in,
    input logic problem_bit_in,
    input logic base_layer_only_rate,
    input logic coef_valid,
    output logic coef_ready,
    input logic [`SBD_COEF_W-1:0] coef_data,
    output logic frame_ready,
    output logic frame_done,
    output logic [31:0] glob_gain_lin,
    output logic [63:0] tenv_lin,
    output logic [15:0] prev_tenv_lin,
    output logic tenv_adjust,
    output logic [1:0] enh_mode,
    output logic problem_flag,
    output logic [7:0] unused_bits_out,
    output logic [23:0] importance,
    output logic shb_valid,
    input logic shb_ready,
    output logic [`SBD_OUT_W-1:0] shb_data,
    output logic [5:0] shb_index,
    output logic shb_final
);
    sbd_pkg::sbd_regs_t r;
    sbd_pkg::sbd_regs_t next_r;
    logic fifo_valid;
    logic fifo_pop_ok;
    logic [`SBD_COEF_W-1:0] fifo_data;
    logic trans;
    logic nn;
    logic pnn;
    logic half;
    logic [4:0] mx;
    logic [4:0] mn;
    logic [7:0] sum;
    logic [`SBD_ENV_W-1:0] e;
    logic [`SBD_ENV_W-1:0] lim;
    logic [`SBD_ENV_W-1:0] diff;
    logic [47:0] mix;
    logic [7:0] w;
    logic [2:0] sb;
    logic [5:0] p;
    logic [5:0] nl;
    logic [5:0] s;
    logic signed [56:0] prod;

    // ============================================================
    // Helpers
    function automatic logic [5:0] map_addr(input logic [6:0] k,
                                            input logic cp);
        map_addr = (cp && !k[5]) ? {1'b1, k[4:0]} : k[5:0];
    endfunction

    function automatic logic [2:0] sb_of(input logic [6:0] k,
                                         input logic tr);
        sb_of = tr ? {1'b0, k[5:4]} : k[5:3];
    endfunction

    // Leading one position; the square root then becomes a halved shift.
    function automatic logic [5:0] msb_of(input logic [`SBD_EN_W-1:0] v);
        msb_of = 6'h0;
        for (int i = 0; i < `SBD_EN_W; i++) begin
            if (v[i]) begin
                msb_of = 6'(i);
            end
        end
    endfunction

    function automatic logic [2:0] rank_of(input logic [7:0][4:0] nv,
                                           input int j);
        rank_of = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (nv[i] > nv[j] || (nv[i] == nv[j] && i < j)) begin
                rank_of = rank_of + 3'h1;
            end
        end
    endfunction

    // ============================================================
    // Input buffer and excitation memory
    sbd_mem_if mif ();

    // The FIFO drains only while loading, so the source sees back-pressure.
    assign fifo_pop_ok = (r.st == sbd_pkg::ST_LOAD);

    sbd_fifo #(.W(`SBD_COEF_W), .D(`SBD_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(coef_valid),
        .in_ready(coef_ready),
        .in_data(coef_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop_ok),
        .out_data(fifo_data)
    );

    sbd_coef_mem u_mem (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mp(mif.mem)
    );

    assign mif.we = fifo_pop_ok && fifo_valid;
    assign mif.waddr = r.k[5:0];
    assign mif.wdata = r.use_noise ? r.seed : fifo_data;
    assign mif.raddr = map_addr(r.k, r.copy);

    // ============================================================
    // Frame sequencer
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        trans = (r.cls == `SBD_CLS_TRANS);
        nn = (r.cls == `SBD_CLS_NORM) || (r.cls == `SBD_CLS_NOISE);
        pnn = (r.prev_cls == `SBD_CLS_NORM) ||
              (r.prev_cls == `SBD_CLS_NOISE);
        half = 1'b0;
        mx = 5'h0;
        mn = 5'h1f;
        sum = 8'h0;
        e = '0;
        lim = '0;
        diff = '0;
        mix = '0;
        w = 8'h0;
        sb = 3'h0;
        p = 6'h0;
        nl = trans ? `SBD_NLOG_T : `SBD_NLOG_NT;
        s = 6'h0;
        prod = '0;
        unique case (r.st)
            sbd_pkg::ST_IDLE: begin
                if (frame_start && frame_erased) begin
                    for (int j = 0; j < 8; j++) begin
                        mix = 48'(r.prev_env[j]) * `SBD_ERASE_ATT;
                        next_r.prev_env[j] = mix[47:8];
                    end
                    next_r.done = 1'b1;
                end else if (frame_start) begin
                    next_r.cls = class_code;
                    next_r.gain = gain_idx;
                    for (int j = 0; j < 8; j++) begin
                        if (class_code == `SBD_CLS_TRANS) begin
                            next_r.norm[j] = (j < 4) ?
                                {1'b0, spec_idx[4*j +: 4]} : 5'h0;
                        end else begin
                            next_r.norm[j] = {codebook_select_flag[j/4],
                                              spec_idx[4*j +: 4]};
                        end
                    end
                    for (int j = 0; j < 4; j++) begin
                        next_r.tenv[j] = {12'h0, tenv_idx[4*j +: 4]};
                    end
                    next_r.prev_tenv = r.tenv[3];
                    next_r.tenv_adj = tenv_adj_bit;
                    next_r.mflag = shb_mode_flag;
                    next_r.l1 = first_enhancement_layer_ok;
                    next_r.l2 = second_enhancement_layer_ok;
                    next_r.unused = unused_bits_in;
                    next_r.pbit = problem_bit_in;
                    next_r.base_only = base_layer_only_rate;
                    next_r.k = 7'h0;
                    next_r.energy = '0;
                    next_r.st = sbd_pkg::ST_PARSE;
                end
            end
            sbd_pkg::ST_PARSE: begin
                for (int j = 0; j < 8; j++) begin
                    if (r.norm[j] > mx) begin
                        mx = r.norm[j];
                    end
                    if (r.norm[j] < mn) begin
                        mn = r.norm[j];
                    end
                    sum = sum + {3'h0, r.norm[j]};
                end
                half = nn && ({mx - mn, 1'b0} > `SBD_SPREAD_Q1) &&
                       (mn < `SBD_MIN_LIM);
                next_r.glin = 32'h1 << r.gain;
                lim = `SBD_SMTH_LIM << r.gain;
                w = nn ? `SBD_W_NN : `SBD_W_OTH;
                for (int j = 0; j < 8; j++) begin
                    e = {31'h0, r.norm[j], 4'h0} << r.gain;
                    if (trans && j < 4 && r.norm[j] == 5'h0) begin
                        e = (`SBD_FLOOR << r.gain) >> 8;
                    end
                    if (half && (10'(r.norm[j]) * `SBD_AVG_DIV <
                                 {2'h0, sum})) begin
                        e = e >> 1;
                    end
                    if (!trans && r.prev_cls != `SBD_CLS_TRANS) begin
                        diff = (e > r.prev_env[j]) ? e - r.prev_env[j] :
                               r.prev_env[j] - e;
                        if (diff <= lim) begin
                            mix = 48'(e) * 48'(w) + 48'(r.prev_env[j]) *
                                  48'(9'h100 - {1'b0, w});
                            e = mix[47:8];
                        end
                    end
                    next_r.env[j] = e;
                    next_r.rank[j] = rank_of(r.norm, j);
                end
                if (trans) begin
                    next_r.cnt = 8'h0;
                end else if (r.cls == `SBD_CLS_HARM) begin
                    next_r.cnt = (r.cnt == 8'hff) ? r.cnt : r.cnt + 8'h1;
                end else begin
                    next_r.cnt = (r.cnt == 8'h0) ? 8'h0 : r.cnt - 8'h1;
                end
                next_r.use_noise = (r.cls == `SBD_CLS_NOISE) &&
                                   (r.prev_cls != `SBD_CLS_HARM);
                next_r.copy = nn && pnn && (next_r.cnt == 8'h0);
                for (int j = 0; j < 4; j++) begin
                    next_r.tenv[j] = trans ?
                        (16'h1 << r.tenv[j][3:0]) : 16'h0;
                end
                next_r.tenv_adj = trans && r.tenv_adj;
                next_r.mode = (nn && pnn) ?
                    (r.mflag ? `SBD_MODE1 : `SBD_MODE0) : `SBD_MODE2;
                next_r.pflag = 1'b0;
                if (nn && pnn && !r.mflag && r.l1 && r.l2 &&
                    r.unused != 8'h0) begin
                    next_r.pflag = r.pbit;
                    next_r.unused = r.unused - 8'h1;
                end
                next_r.st = sbd_pkg::ST_LOAD;
            end
            sbd_pkg::ST_LOAD: begin
                if (fifo_valid) begin
                    // Seed steps even when noise is not the excitation.
                    next_r.seed = r.seed * `SBD_SEED_MUL +
                                  `SBD_SEED_ADD;
                    next_r.k = r.k + 7'h1;
                    if (r.k == `SBD_LAST_K) begin
                        next_r.k = 7'h0;
                        next_r.st = sbd_pkg::ST_EN_A;
                    end
                end
            end
            sbd_pkg::ST_EN_A: begin
                next_r.st = sbd_pkg::ST_EN_B;
            end
            sbd_pkg::ST_EN_B: begin
                prod = $signed(mif.rdata) * $signed(mif.rdata);
                sb = sb_of(r.k, trans);
                next_r.energy[sb] = r.energy[sb] + prod[`SBD_EN_W-1:0];
                next_r.k = r.k + 7'h1;
                next_r.st = sbd_pkg::ST_EN_A;
                if (r.k == `SBD_LAST_K) begin
                    next_r.k = 7'h0;
                    next_r.st = sbd_pkg::ST_OUT_A;
                end
            end
            sbd_pkg::ST_OUT_A: begin
                next_r.st = sbd_pkg::ST_OUT_B;
            end
            sbd_pkg::ST_OUT_B: begin
                if (!r.out_valid) begin
                    sb = sb_of(r.k, trans);
                    p = msb_of(r.energy[sb] + `SBD_EPS);
                    s = (p > nl) ? (p - nl + 6'h1) >> 1 : 6'h0;
                    prod = $signed(mif.rdata) *
                           $signed({1'b0, r.env[sb]});
                    prod = prod >>> s;
                    next_r.out_data = prod[`SBD_OUT_W-1:0];
                    next_r.out_valid = 1'b1;
                end else if (shb_ready) begin
                    next_r.out_valid = 1'b0;
                    next_r.k = r.k + 7'h1;
                    next_r.st = sbd_pkg::ST_OUT_A;
                    if (r.k == `SBD_LAST_K) begin
                        next_r.k = 7'h0;
                        next_r.st = sbd_pkg::ST_DONE;
                    end
                end
            end
            sbd_pkg::ST_DONE: begin
                next_r.prev_env = r.env;
                next_r.prev_cls = r.cls;
                next_r.done = 1'b1;
                next_r.st = sbd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.seed <= `SBD_SEED_INIT;
        end else begin
            r <= next_r;
        end
    end

    // ============================================================
    // Outputs
    assign frame_ready = (r.st == sbd_pkg::ST_IDLE);
    assign frame_done = r.done;
    assign glob_gain_lin = r.glin;
    assign tenv_lin = r.tenv;
    assign prev_tenv_lin = r.prev_tenv;
    assign tenv_adjust = r.tenv_adj;
    assign enh_mode = r.mode;
    assign problem_flag = r.pflag;
    assign unused_bits_out = r.unused;
    assign importance = r.rank;
    assign shb_valid = r.out_valid;
    assign shb_data = r.out_data;
    assign shb_index = r.k[5:0];
    assign shb_final = r.base_only;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_cls_capture: assert property (
        r.st == sbd_pkg::ST_IDLE && frame_start && !frame_erased
        |=> r.cls == $past(class_code) && r.st == sbd_pkg::ST_PARSE)
        else $error("class not captured");
    a_gain_linear: assert property (
        r.st == sbd_pkg::ST_IDLE && frame_start && !frame_erased
        |-> ##2 glob_gain_lin == 32'h1 << $past(gain_idx, 2))
        else $error("linear gain wrong");
    a_tenv_linear: assert property (
        r.st == sbd_pkg::ST_IDLE && frame_start && !frame_erased &&
        class_code == `SBD_CLS_TRANS
        |-> ##2 tenv_lin[15:0] == 16'h1 << $past(tenv_idx[3:0], 2))
        else $error("time envelope wrong");
    a_cnt_clear: assert property (
        r.st == sbd_pkg::ST_PARSE && r.cls == `SBD_CLS_TRANS
        |=> r.cnt == 8'h0)
        else $error("counter not cleared");
    a_cnt_count: assert property (
        r.st == sbd_pkg::ST_PARSE && r.cls == `SBD_CLS_HARM &&
        r.cnt != 8'hff |=> r.cnt == $past(r.cnt) + 8'h1)
        else $error("counter not incremented");
    a_noise_pick: assert property (
        r.st == sbd_pkg::ST_LOAD |-> r.use_noise ==
        (r.cls == `SBD_CLS_NOISE && r.prev_cls != `SBD_CLS_HARM))
        else $error("noise choice wrong");
    a_seed_step: assert property (
        r.st == sbd_pkg::ST_LOAD && fifo_valid |=> r.seed ==
        16'($past(r.seed) * `SBD_SEED_MUL + `SBD_SEED_ADD))
        else $error("seed step wrong");
    a_copy_cond: assert property (
        r.st == sbd_pkg::ST_EN_A
        |-> r.copy == (nn && pnn && r.cnt == 8'h0))
        else $error("copy without cause");
    a_mode_two: assert property (
        r.st == sbd_pkg::ST_LOAD && !(nn && pnn)
        |-> enh_mode == `SBD_MODE2 && !problem_flag)
        else $error("mode two expected");
    a_pflag_gate: assert property (
        r.st == sbd_pkg::ST_LOAD && problem_flag
        |-> enh_mode == `SBD_MODE0 && r.l1 && r.l2)
        else $error("problem flag ungated");
    a_erase_att: assert property (
        r.st == sbd_pkg::ST_IDLE && frame_start && frame_erased
        |=> r.prev_env[0] ==
        40'((48'($past(r.prev_env[0])) * `SBD_ERASE_ATT) >> 8))
        else $error("erasure attenuation wrong");
    a_out_hold: assert property (
        shb_valid && !shb_ready |=> shb_valid && $stable(shb_data))
        else $error("output dropped");

    c_transient: cover property (
        r.st == sbd_pkg::ST_DONE && r.cls == `SBD_CLS_TRANS);
    c_noise: cover property (r.st == sbd_pkg::ST_LOAD && r.use_noise);
    c_copy: cover property (r.st == sbd_pkg::ST_LOAD && r.copy);
    c_erase: cover property (
        r.st == sbd_pkg::ST_IDLE && frame_start && frame_erased);
endmodule

// *** hdl/sbd_cfg.svh ***
// Constants for the super-wideband base extension layer decoder.
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH
`define SBD_CLS_TRANS 2'h0
`define SBD_CLS_NORM 2'h1
`define SBD_CLS_NOISE 2'h2
`define SBD_CLS_HARM 2'h3
`define SBD_MODE0 2'h0
`define SBD_MODE1 2'h1
`define SBD_MODE2 2'h2
`define SBD_NCOEF 64
`define SBD_COEF_W 16
`define SBD_ENV_W 40
`define SBD_EN_W 36
`define SBD_OUT_W 48
`define SBD_FIFO_DEPTH 8
`define SBD_LAST_K 7'h3f
`define SBD_SEED_INIT 16'h52db
`define SBD_SEED_MUL 16'h3039
`define SBD_SEED_ADD 16'h4e85
`define SBD_SPREAD_Q1 6'h05
`define SBD_MIN_LIM 5'h0c
`define SBD_AVG_DIV 10'h14
`define SBD_FLOOR 40'h52
`define SBD_SMTH_LIM 40'h30
`define SBD_W_NN 8'hb3
`define SBD_W_OTH 8'h80
`define SBD_ERASE_ATT 48'hd9
`define SBD_EPS 36'h1
`define SBD_NLOG_T 6'h4
`define SBD_NLOG_NT 6'h3
`endif

// *** hdl/sbd_coef_mem.sv ***
// Excitation coefficient memory with a registered read port.
`timescale 1ns/1ps
`include "sbd_cfg.svh"
module sbd_coef_mem (
    input logic clk_sys,
    input logic rst_n,
    sbd_mem_if.mem mp
);
    typedef struct packed {
        logic [`SBD_NCOEF-1:0][`SBD_COEF_W-1:0] mem;
        logic [`SBD_COEF_W-1:0] rdata;
    } sbd_mem_st_t;
    sbd_mem_st_t r;
    sbd_mem_st_t next_r;

    assign mp.rdata = r.rdata;

    // A read of the address being written returns the old word.
    always_comb begin
        next_r = r;
        if (mp.we) begin
            next_r.mem[mp.waddr] = mp.wdata;
        end
        next_r.rdata = r.mem[mp.raddr];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// *** hdl/sbd_fifo.sv ***
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sbd_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input logic clk_sys,
    input logic rst_n,
    input logic in_valid,
    output logic in_ready,
    input logic [W-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [W-1:0] out_data
);
    // Pointers wrap naturally, so D must be a power of two.
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sbd_fifo_st_t;
    sbd_fifo_st_t r;
    sbd_fifo_st_t next_r;
    logic push;
    logic pop;

    assign in_ready = (r.cnt != (AW+1)'(D));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp = r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// *** hdl/sbd_mem_if.sv ***
// Port bundle between the decoder and its coefficient memory.
`timescale 1ns/1ps
`include "sbd_cfg.svh"
interface sbd_mem_if;
    logic we;
    logic [5:0] waddr;
    logic [`SBD_COEF_W-1:0] wdata;
    logic [5:0] raddr;
    logic [`SBD_COEF_W-1:0] rdata;
    modport ctrl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// *** hdl/sbd_pkg.sv ***
// Types shared by the base extension layer decoder modules.
`include "sbd_cfg.svh"
package sbd_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_PARSE, ST_LOAD, ST_EN_A, ST_EN_B, ST_OUT_A, ST_OUT_B,
        ST_DONE
    } sbd_state_t;

    typedef struct packed {
        sbd_state_t st;
        logic [1:0] cls;
        logic [1:0] prev_cls;
        logic [7:0] cnt;
        logic [4:0] gain;
        logic [31:0] glin;
        logic [7:0][4:0] norm;
        logic [7:0][`SBD_ENV_W-1:0] env;
        logic [7:0][`SBD_ENV_W-1:0] prev_env;
        logic [7:0][`SBD_EN_W-1:0] energy;
        logic [15:0] seed;
        logic [6:0] k;
        logic use_noise;
        logic copy;
        logic [3:0][15:0] tenv;
        logic [15:0] prev_tenv;
        logic tenv_adj;
        logic mflag;
        logic l1;
        logic l2;
        logic pbit;
        logic base_only;
        logic [7:0] unused;
        logic [1:0] mode;
        logic pflag;
        logic [7:0][2:0] rank;
        logic [`SBD_OUT_W-1:0] out_data;
        logic out_valid;
        logic done;
    } sbd_regs_t;
endpackage

// *** test/sbd_core_model.sv ***
// Wideband coefficient source standing in for the core decoder.
`timescale 1ns/1ps
`include "sbd_cfg.svh"
module sbd_core_model (
    input logic clk_sys,
    input logic rst_n,
    input logic go,
    input logic coef_ready,
    output logic coef_valid,
    output logic [`SBD_COEF_W-1:0] coef_data
);
    logic [6:0] left;
    // ============================================================
    // Source
    // A released data line shows the inverse of its last word, so a
    // stale value is never taken for a fresh one.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left <= 7'h0;
            coef_valid <= 1'b0;
            coef_data <= 16'h0;
        end else if (go) begin
            left <= 7'h40;
            coef_valid <= 1'b1;
            coef_data <= 16'h0100;
        end else if (coef_valid && coef_ready) begin
            left <= left - 7'h1;
            coef_valid <= left != 7'h1;
            coef_data <= left != 7'h1 ? coef_data + 16'h0011 : ~coef_data;
        end
    end
endmodule

// *** test/sbd_tb_top.sv ***
// Self-checking bench for the base extension layer decoder.
`timescale 1ns/1ps
`define CHECK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin \
    num_errors++; $display("mismatch %s exp %0h seen %0h", nm, ex, sn); end end
module superwideband_base_layer_decoder_tb_top;
    typedef struct packed {
        logic [1:0] cls;
        logic [4:0] gain;
        logic [5:0] flg;
        logic [7:0] ub;
        logic [15:0] tenv;
        logic [1:0] mode;
        logic pf;
        logic [7:0] uo;
        logic [15:0] pt;
    } sbd_row_t;
    // ============================================================
    // Rows: flg is mode flag, layer 1, layer 2, problem, adjust, base only.
    sbd_row_t rows [8] = '{
        '{2'h1, 5'h00, 6'h01, 8'h00, 16'h0, 2'h2, 1'b0, 8'h00, 16'h0},
        '{2'h2, 5'h1f, 6'h1c, 8'h05, 16'h0, 2'h0, 1'b1, 8'h04, 16'h0},
        '{2'h1, 5'h03, 6'h3c, 8'h05, 16'h0, 2'h1, 1'b0, 8'h05, 16'h0},
        '{2'h2, 5'h07, 6'h14, 8'h03, 16'h0, 2'h0, 1'b0, 8'h03, 16'h0},
        '{2'h2, 5'h01, 6'h1c, 8'h00, 16'h0, 2'h0, 1'b0, 8'h00, 16'h0},
        '{2'h3, 5'h0a, 6'h1c, 8'h05, 16'h0, 2'h2, 1'b0, 8'h05, 16'h0},
        '{2'h0, 5'h05, 6'h03, 8'h00, 16'h3210, 2'h2, 1'b0, 8'h00, 16'h0},
        '{2'h1, 5'h02, 6'h02, 8'h00, 16'hffff, 2'h2, 1'b0, 8'h00, 16'h8}};
    int num_errors = 0;
    int check_count = 0;
    sbd_row_t cur = '0;
    logic clk_sys, rst_n = 1'b0, frame_start = 1'b0, frame_erased = 1'b0;
    logic go = 1'b0, shb_ready = 1'b0, coef_valid, coef_ready, frame_ready;
    logic frame_done, tenv_adjust, problem_flag, shb_valid, shb_final;
    logic [15:0] coef_data, prev_tenv_lin;
    logic [31:0] glob_gain_lin;
    logic [63:0] tenv_lin;
    logic [1:0] enh_mode;
    logic [7:0] unused_bits_out;
    logic [5:0] shb_index, exp_idx = 6'h0;
    logic [47:0] shb_data;
    logic [23:0] importance;
    sbd_base_decoder sbd_base_decoder_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .frame_start(frame_start), .frame_erased(frame_erased),
        .class_code(cur.cls), .gain_idx(cur.gain), .spec_idx(32'h76543210),
        .codebook_select_flag(2'h1), .tenv_idx(cur.tenv),
        .tenv_adj_bit(cur.flg[1]), .shb_mode_flag(cur.flg[5]),
        .first_enhancement_layer_ok(cur.flg[4]),
        .second_enhancement_layer_ok(cur.flg[3]),
        .unused_bits_in(cur.ub), .problem_bit_in(cur.flg[2]),
        .base_layer_only_rate(cur.flg[0]), .coef_valid(coef_valid),
        .coef_ready(coef_ready), .coef_data(coef_data),
        .frame_ready(frame_ready), .frame_done(frame_done),
        .glob_gain_lin(glob_gain_lin), .tenv_lin(tenv_lin),
        .prev_tenv_lin(prev_tenv_lin), .tenv_adjust(tenv_adjust),
        .enh_mode(enh_mode), .problem_flag(problem_flag),
        .unused_bits_out(unused_bits_out), .importance(importance),
        .shb_valid(shb_valid), .shb_ready(shb_ready), .shb_data(shb_data),
        .shb_index(shb_index), .shb_final(shb_final));
    sbd_core_model sbd_core_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .go(go), .coef_ready(coef_ready), .coef_valid(coef_valid),
        .coef_data(coef_data));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // The sink stalls every other cycle to exercise output back-pressure.
    always @(posedge clk_sys) begin
        shb_ready <= ~shb_ready;
        if (rst_n && shb_valid && shb_ready) begin
            `CHECK("index", exp_idx, shb_index)
            `CHECK("final", cur.flg[0], shb_final)
            // Row 0 follows a TRANSIENT history, so nothing is smoothed.
            if (exp_idx == 6'h0 && cur.gain == 5'h0)
                `CHECK("data0", 48'h100, shb_data)
            exp_idx <= exp_idx + 6'h1;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run_frame(input sbd_row_t r, input logic er,
                             input logic early, output int n);
        if (early) begin
            @(posedge clk_sys);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            repeat (12) @(posedge clk_sys);
            #1;
            `CHECK("fifo_full", 1'b0, coef_ready)
        end
        @(posedge clk_sys);
        cur <= r;
        frame_erased <= er;
        frame_start <= 1'b1;
        go <= ~er & ~early;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        go <= 1'b0;
        n = 0;
        // An erased frame pulses done right after the take edge.
        #1;
        while (frame_done !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 3000) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    initial begin
        int n;
        logic [63:0] tl;
        logic [23:0] ord;
        repeat (5) @(posedge clk_sys);
        `CHECK("ready_rst", 1'b1, frame_ready)
        rst_n <= 1'b1;
        for (int r = 0; r < 8; r++) begin
            run_frame(rows[r], 1'b0, r == 1, n);
            tl = 64'h0;
            for (int j = 0; j < 4; j++)
                tl[16*j +: 16] = 16'h1 << rows[r].tenv[4*j +: 4];
            if (rows[r].cls != 2'h0) tl = 64'h0;
            ord = (rows[r].cls != 2'h0) ? 24'h977053 : 24'hfac053;
            `CHECK("order", ord, importance)
            `CHECK("gain", 32'h1 << rows[r].gain, glob_gain_lin)
            `CHECK("tenv", tl, tenv_lin)
            `CHECK("prev_tenv", rows[r].pt, prev_tenv_lin)
            `CHECK("adj", rows[r].flg[1] & ~|rows[r].cls, tenv_adjust)
            `CHECK("mode", rows[r].mode, enh_mode)
            `CHECK("pflag", rows[r].pf, problem_flag)
            `CHECK("unused", rows[r].uo, unused_bits_out)
            $display("row %0d done", r);
        end
        run_frame(rows[7], 1'b1, 1'b0, n);
        `CHECK("erase_done", 1'b1, n == 0)
        $display("erasure done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHECK("gain_rst", 32'h0, glob_gain_lin)
        rst_n <= 1'b1;
        run_frame(rows[0], 1'b0, 1'b0, n);
        `CHECK("mode_rst", 2'h2, enh_mode)
        $display("second reset done");
        tally_and_finish();
    end
endmodule
